// [inc/usdp_pkg.sv]
// constants and carrier types for the uart shadow data port
package usdp_pkg;

	localparam int          USDP_DW        = 8;
	localparam int          USDP_DEPTH     = 16;
	localparam int          USDP_PW        = 4;
	localparam int          USDP_CW        = 5;
	localparam logic [4:0]  USDP_CAP_FIFO  = 5'h10;
	localparam logic [4:0]  USDP_CAP_ONE   = 5'h01;
	localparam logic [4:0]  USDP_CNT_ZERO  = 5'h00;
	localparam logic [3:0]  USDP_PTR_ONE   = 4'h1;

	localparam logic [31:0] USDP_ALIAS_ONE = 32'h5000_1034;
	localparam logic [31:0] USDP_ALIAS_TWO = 32'h5000_1038;
	localparam logic [31:0] USDP_CTRL_ADDR = 32'h5000_1080;
	localparam logic [31:0] USDP_LST_ADDR  = 32'h5000_1084;
	localparam logic [31:0] USDP_IST_ADDR  = 32'h5000_1088;
	localparam logic [31:0] USDP_IMSK_ADDR = 32'h5000_108c;

	localparam int          USDP_CTRL_FEN  = 0;
	localparam int          USDP_CTRL_IR   = 1;
	localparam int          USDP_LST_RDY   = 0;
	localparam int          USDP_LST_OVR   = 1;
	localparam int          USDP_LST_TXE   = 5;

	localparam int          USDP_IRQ_W     = 4;
	localparam int          USDP_IRQ_RXAV  = 0;
	localparam int          USDP_IRQ_OVR   = 1;
	localparam int          USDP_IRQ_TLOST = 2;
	localparam int          USDP_IRQ_TXE   = 3;
	localparam logic [3:0]  USDP_IRQ_RST   = 4'h0;

	typedef struct packed
	{
		logic [31:0] addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} usdp_bus_t;

	typedef struct packed
	{
		logic               valid;
		logic [USDP_DW-1:0] data;
	} usdp_rx_t;

endpackage : usdp_pkg

// [core/usdp_top.sv]
// uart shadow data port: alias data slots, rx/tx fifos, status and interrupt
// Contract
// - two consecutive word addresses alias the receive and transmit data path
// - read returns low byte from serial input, or infrared input in infrared mode
// - read data is meaningful only while the data ready flag is set
// - fifos off: unread byte is overwritten by next arrival, overrun flagged
// - fifos on: read returns and pops the oldest receive fifo entry
// - receive fifo full: keep contents, drop arrival, flag overrun
// - write low byte goes out on serial or infrared output by mode
// - fifos off: a write clears the transmit holding empty flag
// - fifos off: a further write before empty replaces the pending byte
// - fifos on: accept writes up to transmit fifo depth sixteen
// - writes while transmit fifo is full are discarded and set the tx lost interrupt status
//
// The plain strobed port was decided locally.
`timescale 1ns/10ps
module usdp_top
	import usdp_pkg::*;
(
	input  wire logic         clk,           // 40 MHz clock
	input  wire logic         reset,         // async reset, active high
	input  wire usdp_bus_t    bus,           // register bus request
	output logic [31:0]       rd_data,       // read data, cycle after read
	input  wire usdp_rx_t     rx_uart,       // byte from serial receiver
	input  wire usdp_rx_t     rx_ir,         // byte from infrared receiver
	output logic [USDP_DW-1:0] tx_byte,      // byte to transmit
	output logic              tx_uart_valid, // byte offered to serial output
	output logic              tx_ir_valid,   // byte offered to infrared output
	input  wire logic         tx_ready,      // serializer takes the byte
	output logic              irq            // level interrupt
);

	logic [USDP_DW-1:0]   rx_mem [USDP_DEPTH];
	logic [USDP_DW-1:0]   tx_mem [USDP_DEPTH];
	logic [USDP_PW-1:0]   rx_rd_ptr_q, rx_wr_ptr_q, tx_rd_ptr_q, tx_wr_ptr_q;
	logic [USDP_CW-1:0]   rx_cnt_q, tx_cnt_q, cap;
	logic                 fifo_en_q, ir_mode_q, ovr_q;
	logic [USDP_IRQ_W-1:0] ist_q, imsk_q, ist_evt;
	logic [31:0]          rd_data_q, rd_word;
	usdp_rx_t             rx_in;
	logic                 alias_hit, rd_alias, wr_alias, ctrl_wr, flush;
	logic                 rx_full, rx_pop, rx_push, rx_overwrite, rx_drop;
	logic                 tx_full, tx_pop, tx_push, tx_replace, tx_lost, tx_empty;
	logic [USDP_DW-1:0]   rx_head;

	assign alias_hit = (bus.addr == USDP_ALIAS_ONE) || (bus.addr == USDP_ALIAS_TWO);
	assign rd_alias  = bus.rd && alias_hit;
	assign wr_alias  = bus.wr && alias_hit;
	assign ctrl_wr   = bus.wr && (bus.addr == USDP_CTRL_ADDR);
	// switching fifo mode empties both paths, as mixed depths would lose order
	assign flush     = ctrl_wr && (bus.wdata[USDP_CTRL_FEN] != fifo_en_q);
	assign cap       = fifo_en_q ? USDP_CAP_FIFO : USDP_CAP_ONE;

	// receive path
	assign rx_in        = ir_mode_q ? rx_ir : rx_uart;
	assign rx_head      = rx_mem[rx_rd_ptr_q];
	assign rx_full      = (rx_cnt_q == cap);
	assign rx_pop       = rd_alias && (rx_cnt_q != USDP_CNT_ZERO);
	assign rx_push      = rx_in.valid && (!rx_full || rx_pop) && !flush;
	assign rx_overwrite = rx_in.valid && rx_full && !rx_pop && !fifo_en_q && !flush;
	assign rx_drop      = rx_in.valid && rx_full && !rx_pop && fifo_en_q && !flush;

	always_ff @(posedge clk)
	begin
		if (rx_push)
		begin
			rx_mem[rx_wr_ptr_q] <= rx_in.data;
		end
		else if (rx_overwrite)
		begin
			rx_mem[rx_rd_ptr_q] <= rx_in.data;
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			rx_rd_ptr_q <= '0;
			rx_wr_ptr_q <= '0;
			rx_cnt_q    <= USDP_CNT_ZERO;
		end
		else if (flush)
		begin
			rx_rd_ptr_q <= '0;
			rx_wr_ptr_q <= '0;
			rx_cnt_q    <= USDP_CNT_ZERO;
		end
		else
		begin
			if (rx_pop)
			begin
				rx_rd_ptr_q <= rx_rd_ptr_q + USDP_PTR_ONE;
			end
			if (rx_push)
			begin
				rx_wr_ptr_q <= rx_wr_ptr_q + USDP_PTR_ONE;
			end
			if (rx_push && !rx_pop)
			begin
				rx_cnt_q <= rx_cnt_q + USDP_CAP_ONE;
			end
			else if (rx_pop && !rx_push)
			begin
				rx_cnt_q <= rx_cnt_q - USDP_CAP_ONE;
			end
		end
	end

	// transmit path; a late write from the master is absorbed, never stalled
	assign tx_empty   = (tx_cnt_q == USDP_CNT_ZERO);
	assign tx_full    = (tx_cnt_q == cap);
	assign tx_pop     = !tx_empty && tx_ready;
	assign tx_push    = wr_alias && (!tx_full || tx_pop) && !flush;
	assign tx_replace = wr_alias && tx_full && !tx_pop && !fifo_en_q && !flush;
	assign tx_lost    = wr_alias && tx_full && !tx_pop && fifo_en_q && !flush;
	assign tx_byte    = tx_mem[tx_rd_ptr_q];
	assign tx_uart_valid = !tx_empty && !ir_mode_q;
	assign tx_ir_valid   = !tx_empty && ir_mode_q;

	always_ff @(posedge clk)
	begin
		if (tx_push)
		begin
			tx_mem[tx_wr_ptr_q] <= bus.wdata[USDP_DW-1:0];
		end
		else if (tx_replace)
		begin
			tx_mem[tx_rd_ptr_q] <= bus.wdata[USDP_DW-1:0];
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			tx_rd_ptr_q <= '0;
			tx_wr_ptr_q <= '0;
			tx_cnt_q    <= USDP_CNT_ZERO;
		end
		else if (flush)
		begin
			tx_rd_ptr_q <= '0;
			tx_wr_ptr_q <= '0;
			tx_cnt_q    <= USDP_CNT_ZERO;
		end
		else
		begin
			if (tx_pop)
			begin
				tx_rd_ptr_q <= tx_rd_ptr_q + USDP_PTR_ONE;
			end
			if (tx_push)
			begin
				tx_wr_ptr_q <= tx_wr_ptr_q + USDP_PTR_ONE;
			end
			if (tx_push && !tx_pop)
			begin
				tx_cnt_q <= tx_cnt_q + USDP_CAP_ONE;
			end
			else if (tx_pop && !tx_push)
			begin
				tx_cnt_q <= tx_cnt_q - USDP_CAP_ONE;
			end
		end
	end

	// control register
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			fifo_en_q <= 1'b0;
			ir_mode_q <= 1'b0;
		end
		else if (ctrl_wr)
		begin
			fifo_en_q <= bus.wdata[USDP_CTRL_FEN];
			ir_mode_q <= bus.wdata[USDP_CTRL_IR];
		end
	end

	// overrun flag: a new overrun in the reading cycle survives the clear
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			ovr_q <= 1'b0;
		end
		else
		begin
			ovr_q <= (ovr_q && !(bus.rd && bus.addr == USDP_LST_ADDR))
				|| rx_overwrite || rx_drop;
		end
	end

	// interrupt status, cleared by read, set wins
	always_comb
	begin
		ist_evt                 = '0;
		ist_evt[USDP_IRQ_RXAV]  = rx_push;
		ist_evt[USDP_IRQ_OVR]   = rx_overwrite || rx_drop;
		ist_evt[USDP_IRQ_TLOST] = tx_lost;
		ist_evt[USDP_IRQ_TXE]   = tx_pop && !tx_push && (tx_cnt_q == USDP_CAP_ONE);
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			ist_q <= USDP_IRQ_RST;
		end
		else if (bus.rd && bus.addr == USDP_IST_ADDR)
		begin
			ist_q <= ist_evt;
		end
		else
		begin
			ist_q <= ist_q | ist_evt;
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			imsk_q <= USDP_IRQ_RST;
		end
		else if (bus.wr && bus.addr == USDP_IMSK_ADDR)
		begin
			imsk_q <= bus.wdata[USDP_IRQ_W-1:0];
		end
	end

	assign irq = |(ist_q & imsk_q);

	// read mux; an empty receive path reads zero rather than stale bytes
	always_comb
	begin
		rd_word = '0;
		unique case (bus.addr)
			USDP_ALIAS_ONE, USDP_ALIAS_TWO:
				if (rx_cnt_q != USDP_CNT_ZERO)
					rd_word[USDP_DW-1:0] = rx_head;
			USDP_CTRL_ADDR:
			begin
				rd_word[USDP_CTRL_FEN] = fifo_en_q;
				rd_word[USDP_CTRL_IR]  = ir_mode_q;
			end
			USDP_LST_ADDR:
			begin
				rd_word[USDP_LST_RDY]  = (rx_cnt_q != USDP_CNT_ZERO);
				rd_word[USDP_LST_OVR]  = ovr_q;
				rd_word[USDP_LST_TXE]  = tx_empty;
			end
			USDP_IST_ADDR:
				rd_word[USDP_IRQ_W-1:0] = ist_q;
			USDP_IMSK_ADDR:
				rd_word[USDP_IRQ_W-1:0] = imsk_q;
			default:
				rd_word = '0;
		endcase
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			rd_data_q <= '0;
		end
		else if (bus.rd)
		begin
			rd_data_q <= rd_word;
		end
	end

	assign rd_data = rd_data_q;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_read_full;
		rd_alias && rx_cnt_q != USDP_CNT_ZERO;
	endsequence
	sequence s_empty_write;
		tx_empty && wr_alias && !flush;
	endsequence

	property p_alias_read;
		s_read_full |=> rd_data_q[USDP_DW-1:0] == $past(rx_head);
	endproperty
	a_alias_read: assert property (p_alias_read) else $error("alias read wrong byte");
	property p_ir_source;
		ir_mode_q && rx_ir.valid && rx_cnt_q == USDP_CNT_ZERO && !flush
			|=> rx_head == $past(rx_ir.data) && rx_cnt_q == USDP_CAP_ONE;
	endproperty
	a_ir_source: assert property (p_ir_source) else $error("ir byte not captured");
	property p_empty_zero;
		rd_alias && rx_cnt_q == USDP_CNT_ZERO |=> rd_data_q == '0;
	endproperty
	a_empty_zero: assert property (p_empty_zero) else $error("empty read not zero");
	property p_overwrite;
		rx_overwrite |=> ovr_q && rx_head == $past(rx_in.data) && rx_cnt_q == USDP_CAP_ONE;
	endproperty
	a_overwrite: assert property (p_overwrite) else $error("overwrite wrong");
	property p_pop;
		s_read_full and !rx_push and !flush |=> rx_cnt_q == $past(rx_cnt_q) - USDP_CAP_ONE;
	endproperty
	a_pop: assert property (p_pop) else $error("read did not pop");
	property p_drop;
		rx_drop |=> ovr_q && rx_cnt_q == USDP_CAP_FIFO && rx_head == $past(rx_head);
	endproperty
	a_drop: assert property (p_drop) else $error("full rx fifo not kept");
	property p_tx_first;
		s_empty_write |=> !tx_empty && tx_byte == $past(bus.wdata[USDP_DW-1:0])
			&& (tx_ir_valid == ir_mode_q) && (tx_uart_valid == !ir_mode_q);
	endproperty
	a_tx_first: assert property (p_tx_first) else $error("tx byte not offered");
	property p_replace;
		tx_replace |=> tx_byte == $past(bus.wdata[USDP_DW-1:0]) && tx_cnt_q == USDP_CAP_ONE;
	endproperty
	a_replace: assert property (p_replace) else $error("pending byte not replaced");
	property p_fill;
		fifo_en_q && wr_alias && !tx_pop && !flush && tx_cnt_q < USDP_CAP_FIFO
			|=> tx_cnt_q == $past(tx_cnt_q) + USDP_CAP_ONE;
	endproperty
	a_fill: assert property (p_fill) else $error("tx fifo write lost");
	property p_lost;
		tx_lost |=> tx_cnt_q == USDP_CAP_FIFO && tx_wr_ptr_q == $past(tx_wr_ptr_q);
	endproperty
	a_lost: assert property (p_lost) else $error("full tx fifo accepted write");
	property p_upper_zero;
		rd_alias |=> rd_data_q[31:USDP_DW] == '0;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("alias upper bits set");

endmodule : usdp_top

// [dv/usdp_far_end.sv]
// serial-side partner: receivers feeding bytes in, serializer taking bytes out
`timescale 1ns/10ps
module usdp_far_end
	import usdp_pkg::*;
(
	input  wire logic               clk,      // bus clock
	input  wire logic               reset,    // async reset, active high
	input  wire logic               hold,     // stall the serializer
	input  wire logic [USDP_DW-1:0] tx_byte,  // offered byte
	input  wire logic               tx_valid, // either output offers a byte
	output logic                    tx_ready, // take strobe
	output usdp_rx_t                rx_uart,  // serial receiver byte
	output usdp_rx_t                rx_ir     // infrared receiver byte
);
	logic [USDP_DW-1:0] got[$];

	initial
	begin
		rx_uart = '0;
		rx_ir   = '0;
	end

	// takes every other cycle so the design also meets a slow consumer
	always @(posedge clk or posedge reset)
		if (reset)
			tx_ready <= 1'b0;
		else
			tx_ready <= !hold && !tx_ready;

	always @(posedge clk)
		if (!reset && tx_valid && tx_ready)
			got.push_back(tx_byte);

	task automatic send(input logic ir, input logic [USDP_DW-1:0] d);
		@(posedge clk);
		if (ir)
			rx_ir <= '{1'b1, d};
		else
			rx_uart <= '{1'b1, d};
		@(posedge clk);
		// scramble data once valid drops, so a stale byte is never mistaken as held
		rx_ir   <= '{1'b0, ~rx_ir.data};
		rx_uart <= '{1'b0, ~rx_uart.data};
	endtask : send
endmodule : usdp_far_end

// [dv/test_uart_shadow_data_port.sv]
// self-checking bench for the uart shadow data port
`timescale 1ns/10ps
`define CHK(a, b) \
	begin \
		n_tests++; \
		if ((a) !== (b)) \
		begin \
			fail_count++; \
			$display("Error %0t: got %h want %h", $time, (a), (b)); \
		end \
	end
module test_uart_shadow_data_port;
	import usdp_pkg::*;
	logic               clk;
	logic               reset;
	logic               hold;
	usdp_bus_t          bus;
	logic [31:0]        rd_data;
	usdp_rx_t           rx_uart;
	usdp_rx_t           rx_ir;
	logic [USDP_DW-1:0] tx_byte;
	logic               tx_uart_valid;
	logic               tx_ir_valid;
	logic               tx_ready;
	logic               irq;
	logic [31:0]        v;
	int                 fail_count;
	int                 n_tests;

	usdp_top dut (.clk(clk), .reset(reset), .bus(bus), .rd_data(rd_data), .rx_uart(rx_uart),
		.rx_ir(rx_ir), .tx_byte(tx_byte), .tx_uart_valid(tx_uart_valid),
		.tx_ir_valid(tx_ir_valid), .tx_ready(tx_ready), .irq(irq));
	usdp_far_end far (.clk(clk), .reset(reset), .hold(hold), .tx_byte(tx_byte),
		.tx_valid(tx_uart_valid | tx_ir_valid), .tx_ready(tx_ready), .rx_uart(rx_uart),
		.rx_ir(rx_ir));

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
		#1;
	endtask : wr

	task automatic chk_rd(input logic [31:0] a, input logic [31:0] exp);
		@(posedge clk);
		bus <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1;
		v = rd_data;
		`CHK(v, exp)
	endtask : chk_rd

	// bounded wait for the serializer to have taken n bytes
	task automatic wait_got(input int n);
		for (int k = 0; k < 300 && far.got.size() < n; k++)
			@(posedge clk);
		if (far.got.size() < n)
		begin
			fail_count++;
			$display("Error %0t: serializer starved", $time);
		end
		#1;
	endtask : wait_got

	initial
	begin
		fail_count = 0;
		n_tests = 0;
		reset = 1'b1;
		hold = 1'b1;
		bus = '0;
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		chk_rd(USDP_ALIAS_ONE, 32'h0);
		chk_rd(USDP_LST_ADDR, 32'h20);
		chk_rd(32'h5000_1030, 32'h0);
		$display("test reset done");

		wr(USDP_IMSK_ADDR, 32'h2);
		wr(USDP_ALIAS_ONE, 32'hffff_ffa5);
		`CHK(tx_uart_valid, 1'b1)
		chk_rd(USDP_LST_ADDR, 32'h0);
		wr(USDP_ALIAS_TWO, 32'h5c);
		`CHK(tx_byte, 8'h5c)
		hold = 1'b0;
		wait_got(1);
		repeat (6) @(posedge clk);
		`CHK(far.got.size(), 1)
		`CHK(far.got[0], 8'h5c)
		chk_rd(USDP_LST_ADDR, 32'h20);
		$display("test fifo off transmit done");

		far.send(1'b0, 8'h11);
		far.send(1'b0, 8'h22);
		chk_rd(USDP_LST_ADDR, 32'h23);
		`CHK(irq, 1'b1)
		chk_rd(USDP_IST_ADDR, 32'h0b);
		`CHK(irq, 1'b0)
		chk_rd(USDP_ALIAS_TWO, 32'h22);
		chk_rd(USDP_LST_ADDR, 32'h20);
		$display("test fifo off receive done");

		hold = 1'b1;
		wr(USDP_CTRL_ADDR, 32'h1);
		for (int i = 0; i < 17; i++)
			wr(i[0] ? USDP_ALIAS_TWO : USDP_ALIAS_ONE, 32'h100 + i);
		chk_rd(USDP_IST_ADDR, 32'h4);
		hold = 1'b0;
		wait_got(17);
		repeat (6) @(posedge clk);
		`CHK(far.got.size(), 17)
		for (int i = 0; i < 16; i++)
			`CHK(far.got[i + 1], i[7:0])
		$display("test fifo transmit done");

		wr(USDP_CTRL_ADDR, 32'h3);
		for (int i = 0; i < 17; i++)
			far.send(1'b1, 8'h40 + i[7:0]);
		far.send(1'b0, 8'hee);
		chk_rd(USDP_LST_ADDR, 32'h23);
		for (int i = 0; i < 16; i++)
			chk_rd(i[0] ? USDP_ALIAS_TWO : USDP_ALIAS_ONE, 32'h40 + i);
		chk_rd(USDP_ALIAS_ONE, 32'h0);
		chk_rd(USDP_LST_ADDR, 32'h20);
		$display("test fifo receive done");

		hold = 1'b1;
		wr(USDP_ALIAS_ONE, 32'h3c);
		`CHK(tx_ir_valid, 1'b1)
		`CHK(tx_uart_valid, 1'b0)
		hold = 1'b0;
		wait_got(18);
		`CHK(far.got[17], 8'h3c)
		$display("test infrared transmit done");
		tally_and_finish();
	end
endmodule : test_uart_shadow_data_port
